// ===== hw/dpsc_defs.svh
// address map, field positions, reset values and timing counts of the power save controller
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH

`define DPSC_IDX_CFG       12'h01f0
`define DPSC_IDX_STAT      12'h01f1
`define DPSC_IDX_MODE      12'h01f2
`define DPSC_IDX_IRQ_STAT  12'h01f3
`define DPSC_IDX_IRQ_MASK  12'h01f4
`define DPSC_IDX_W         12

`define DPSC_CFG_PS_BIT    0
`define DPSC_STAT_LCD_BIT  0
`define DPSC_STAT_MEM_BIT  1
`define DPSC_MODE_LCD_BIT  0
`define DPSC_MODE_CRT_BIT  1

`define DPSC_EV_LCD_DOWN   0
`define DPSC_EV_MEM_SR     1
`define DPSC_EV_MEM_WAKE   2
`define DPSC_EV_MEM_BLOCK  3
`define DPSC_EV_LCD_UP     4
`define DPSC_EV_W          5

`define DPSC_CFG_RST       8'h00
`define DPSC_MODE_RST      8'h00
`define DPSC_IRQ_MASK_RST  5'h00

`define DPSC_CLK_PERIOD_NS 10
`define DPSC_LCD_SEQ_NS    2000
`define DPSC_MEM_SD_NS     300
`define DPSC_MEM_WAKE_NS   300
`define DPSC_LCD_SEQ_CYC   ((`DPSC_LCD_SEQ_NS + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS)
`define DPSC_MEM_SD_CYC    ((`DPSC_MEM_SD_NS + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS)
`define DPSC_MEM_WAKE_CYC  ((`DPSC_MEM_WAKE_NS + `DPSC_CLK_PERIOD_NS - 1) / `DPSC_CLK_PERIOD_NS)
`define DPSC_TMR_W         12

`endif

// ===== hw/dpsc_pkg.sv
// types of the power save controller
package dpsc_pkg;

  typedef enum logic [3:0] {
    LCD_OFF  = 4'b0001,
    LCD_UP   = 4'b0010,
    LCD_ON   = 4'b0100,
    LCD_DOWN = 4'b1000
  } dpsc_lcd_st_t;

  typedef enum logic [3:0] {
    MEM_ACT   = 4'b0001,
    MEM_DRAIN = 4'b0010,
    MEM_SR    = 4'b0100,
    MEM_WAKE  = 4'b1000
  } dpsc_mem_st_t;

  typedef struct packed {
    logic lcd_out_en;
    logic crt_out_en;
    logic lcd_clk_en;
    logic crt_clk_en;
    logic mem_clk_en;
  } dpsc_disp_t;

endpackage

// ===== hw/dpsc_timer.sv
// one-shot down counter that pulses done when a loaded cycle count runs out
`timescale 1ns/1ps
module dpsc_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [11:0] load,
  output logic             busy,
  output logic             done
);

  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic        last;

  assign last     = busy && (cnt_reg == 12'h0001);
  assign cnt_next = start ? load : (busy ? cnt_reg - 12'h0001 : cnt_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 12'h0000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      cnt_reg <= stop ? 12'h0000 : cnt_next;
      busy    <= !stop && (start || (busy && !last));
      done    <= !stop && !start && last;
    end
  end

endmodule // dpsc_timer

// ===== hw/dpsc_top.sv
// power save controller: apb registers, lcd panel and sdram sequencing, display and clock gating
`timescale 1ns/1ps
`include "dpsc_defs.svh"

module dpsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mem_req,
  input  wire logic        mem_busy,
  output logic             mem_gnt,
  output logic             sdram_self_refresh,
  output dpsc_pkg::dpsc_disp_t disp,
  output logic             irq
);

  // apb decode
  logic        setup_ph;
  logic        wr_done;
  logic        wr_cfg;
  logic        wr_mode;
  logic        wr_irqs;
  logic        wr_irqm;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_mode;
  logic        hit_irqs;
  logic        hit_irqm;
  logic        hit_any;
  logic        lane0;
  logic [`DPSC_IDX_W+1:0] a_cfg;
  logic [`DPSC_IDX_W+1:0] a_stat;
  logic [`DPSC_IDX_W+1:0] a_mode;
  logic [`DPSC_IDX_W+1:0] a_irqs;
  logic [`DPSC_IDX_W+1:0] a_irqm;

  // register index times four gives the byte address
  assign a_cfg  = {`DPSC_IDX_CFG, 2'b00};
  assign a_stat = {`DPSC_IDX_STAT, 2'b00};
  assign a_mode = {`DPSC_IDX_MODE, 2'b00};
  assign a_irqs = {`DPSC_IDX_IRQ_STAT, 2'b00};
  assign a_irqm = {`DPSC_IDX_IRQ_MASK, 2'b00};

  assign hit_cfg  = ({2'b00, paddr} == a_cfg);
  assign hit_stat = ({2'b00, paddr} == a_stat);
  assign hit_mode = ({2'b00, paddr} == a_mode);
  assign hit_irqs = ({2'b00, paddr} == a_irqs);
  assign hit_irqm = ({2'b00, paddr} == a_irqm);
  assign hit_any  = hit_cfg | hit_stat | hit_mode | hit_irqs | hit_irqm;

  // pready is registered, so every transfer takes exactly one wait state
  assign setup_ph = psel && penable && !pready;
  // writes land only on the completing edge, and never on an unmapped address
  assign wr_done  = psel && penable && pready && pwrite && hit_any;
  assign lane0    = pstrb[0];
  // lane 0 carries every implemented bit, so it alone gates writes
  assign wr_cfg   = wr_done && hit_cfg && lane0;
  assign wr_mode  = wr_done && hit_mode && lane0;
  assign wr_irqs  = wr_done && hit_irqs && lane0;
  assign wr_irqm  = wr_done && hit_irqm && lane0;

  // registers
  logic [7:0]             cfg_reg;
  logic [7:0]             mode_reg;
  logic [`DPSC_EV_W-1:0]  irq_stat_reg;
  logic [`DPSC_EV_W-1:0]  irq_stat_next;
  logic [`DPSC_EV_W-1:0]  irq_mask_reg;
  logic [`DPSC_EV_W-1:0]  events;
  logic [`DPSC_EV_W-1:0]  irq_clr;
  logic                   ps_en;
  logic                   lcd_sel;
  logic                   crt_sel;
  logic [7:0]             stat_val;

  assign ps_en   = cfg_reg[`DPSC_CFG_PS_BIT];
  assign lcd_sel = mode_reg[`DPSC_MODE_LCD_BIT];
  assign crt_sel = mode_reg[`DPSC_MODE_CRT_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `DPSC_CFG_RST;
    end else if (wr_cfg) begin
      // only bit 0 is implemented, so clearing it is also how power save ends
      cfg_reg <= {7'b000_0000, pwdata[`DPSC_CFG_PS_BIT]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= `DPSC_MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= {6'b00_0000, pwdata[1:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `DPSC_IRQ_MASK_RST;
    end else if (wr_irqm) begin
      irq_mask_reg <= pwdata[`DPSC_EV_W-1:0];
    end
  end

  // write one to clear; an event in the clearing cycle still sets the bit
  assign irq_clr       = wr_irqs ? pwdata[`DPSC_EV_W-1:0] : {`DPSC_EV_W{1'b0}};
  assign irq_stat_next = (irq_stat_reg & ~irq_clr) | events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= {`DPSC_EV_W{1'b0}};
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // lcd panel sequencing
  dpsc_pkg::dpsc_lcd_st_t lcd_st_reg;
  dpsc_pkg::dpsc_lcd_st_t lcd_st_next;
  logic                   lcd_want;
  logic                   lcd_tmr_start;
  logic                   lcd_tmr_done;
  logic                   lcd_tmr_busy;
  logic [11:0]            lcd_load;

  // the panel is wanted only when selected and power save is off
  assign lcd_want = lcd_sel && !ps_en;
  assign lcd_load = 12'(`DPSC_LCD_SEQ_CYC);

  always_comb begin
    lcd_st_next   = lcd_st_reg;
    lcd_tmr_start = 1'b0;
    unique case (lcd_st_reg)
      dpsc_pkg::LCD_OFF: begin
        if (lcd_want) begin
          lcd_st_next   = dpsc_pkg::LCD_UP;
          lcd_tmr_start = 1'b1;
        end
      end
      dpsc_pkg::LCD_UP: begin
        // a power-up is finished before a pending power-down is honoured
        if (lcd_tmr_done) begin
          lcd_st_next = lcd_want ? dpsc_pkg::LCD_ON : dpsc_pkg::LCD_DOWN;
          lcd_tmr_start = !lcd_want;
        end
      end
      dpsc_pkg::LCD_ON: begin
        if (!lcd_want) begin
          lcd_st_next   = dpsc_pkg::LCD_DOWN;
          lcd_tmr_start = 1'b1;
        end
      end
      dpsc_pkg::LCD_DOWN: begin
        if (lcd_tmr_done) begin
          lcd_st_next = dpsc_pkg::LCD_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcd_st_reg <= dpsc_pkg::LCD_OFF;
    end else begin
      lcd_st_reg <= lcd_st_next;
    end
  end

  dpsc_timer u_lcd_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (lcd_tmr_start),
    .stop    (1'b0),
    .load    (lcd_load),
    .busy    (lcd_tmr_busy),
    .done    (lcd_tmr_done)
  );

  // sdram power down
  dpsc_pkg::dpsc_mem_st_t mem_st_reg;
  dpsc_pkg::dpsc_mem_st_t mem_st_next;
  logic                   mem_tmr_start;
  logic                   mem_tmr_stop;
  logic                   mem_tmr_done;
  logic                   mem_tmr_busy;
  logic                   mem_drain_go;
  logic [11:0]            mem_load;
  logic                   mem_open;
  logic                   mem_in_drain;
  logic                   mem_in_sr;

  assign mem_in_drain = (mem_st_reg == dpsc_pkg::MEM_DRAIN);
  assign mem_in_sr    = (mem_st_reg == dpsc_pkg::MEM_SR);
  // the shutdown delay only starts once outstanding memory traffic has drained
  assign mem_drain_go = mem_in_drain && !mem_busy && !mem_tmr_busy && !mem_tmr_done;
  assign mem_load     = mem_in_sr ? 12'(`DPSC_MEM_WAKE_CYC) : 12'(`DPSC_MEM_SD_CYC);

  always_comb begin
    mem_st_next   = mem_st_reg;
    mem_tmr_start = 1'b0;
    mem_tmr_stop  = 1'b0;
    unique case (mem_st_reg)
      dpsc_pkg::MEM_ACT: begin
        if (ps_en) begin
          mem_st_next = dpsc_pkg::MEM_DRAIN;
        end
      end
      dpsc_pkg::MEM_DRAIN: begin
        if (!ps_en) begin
          mem_st_next  = dpsc_pkg::MEM_ACT;
          mem_tmr_stop = 1'b1;
        end else if (mem_tmr_done) begin
          mem_st_next = dpsc_pkg::MEM_SR;
        end else begin
          mem_tmr_start = mem_drain_go;
        end
      end
      dpsc_pkg::MEM_SR: begin
        if (!ps_en) begin
          mem_st_next   = dpsc_pkg::MEM_WAKE;
          mem_tmr_start = 1'b1;
        end
      end
      dpsc_pkg::MEM_WAKE: begin
        // re-entry requested mid-wake waits for the exit to complete first
        if (mem_tmr_done) begin
          mem_st_next = dpsc_pkg::MEM_ACT;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_st_reg <= dpsc_pkg::MEM_ACT;
    end else begin
      mem_st_reg <= mem_st_next;
    end
  end

  dpsc_timer u_mem_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (mem_tmr_start),
    .stop    (mem_tmr_stop),
    .load    (mem_load),
    .busy    (mem_tmr_busy),
    .done    (mem_tmr_done)
  );

  // access only while the interface is fully active and power save is off
  assign mem_open = (mem_st_reg == dpsc_pkg::MEM_ACT) && !ps_en;

  // status and events
  logic lcd_down_now;
  logic mem_down_now;

  assign lcd_down_now = (lcd_st_reg == dpsc_pkg::LCD_OFF);
  assign mem_down_now = mem_in_sr;
  assign stat_val     = {6'b00_0000, mem_down_now, lcd_down_now};

  assign events[`DPSC_EV_LCD_DOWN]  = (lcd_st_reg == dpsc_pkg::LCD_DOWN) && (lcd_st_next == dpsc_pkg::LCD_OFF);
  assign events[`DPSC_EV_LCD_UP]    = (lcd_st_reg == dpsc_pkg::LCD_UP) && (lcd_st_next == dpsc_pkg::LCD_ON);
  assign events[`DPSC_EV_MEM_SR]    = (mem_st_reg == dpsc_pkg::MEM_DRAIN) && (mem_st_next == dpsc_pkg::MEM_SR);
  assign events[`DPSC_EV_MEM_WAKE]  = (mem_st_reg == dpsc_pkg::MEM_WAKE) && (mem_st_next == dpsc_pkg::MEM_ACT);
  // flags a host that ignored the no-access rule
  assign events[`DPSC_EV_MEM_BLOCK] = mem_req && !mem_open;

  // outputs
  logic                 lcd_in_on;
  dpsc_pkg::dpsc_disp_t disp_next;

  assign lcd_in_on = (lcd_st_reg == dpsc_pkg::LCD_ON);

  always_comb begin
    disp_next            = '0;
    disp_next.lcd_out_en = lcd_in_on && lcd_want;
    disp_next.crt_out_en = crt_sel && !ps_en;
    // pixel clock stays on while the panel is still sequencing
    disp_next.lcd_clk_en = !lcd_down_now;
    disp_next.crt_clk_en = crt_sel && !ps_en;
    disp_next.mem_clk_en = !mem_down_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp               <= '0;
      mem_gnt            <= 1'b0;
      sdram_self_refresh <= 1'b0;
    end else begin
      disp               <= disp_next;
      mem_gnt            <= mem_req && mem_open;
      sdram_self_refresh <= (mem_st_next == dpsc_pkg::MEM_SR);
    end
  end

  // read data
  logic [31:0] rd_mux;

  assign rd_mux = hit_cfg  ? {24'h00_0000, cfg_reg} :
                  hit_stat ? {24'h00_0000, stat_val} :
                  hit_mode ? {24'h00_0000, mode_reg} :
                  hit_irqs ? {27'h000_0000, irq_stat_reg} :
                  hit_irqm ? {27'h000_0000, irq_mask_reg} :
                  32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // dpsc_top

// ===== bench/dpsc_top_properties.sv
// port-level assertions of the power save controller
`timescale 1ns/1ps
module dpsc_top_properties (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 mem_req,
  input wire logic                 mem_gnt,
  input wire logic                 sdram_self_refresh,
  input wire dpsc_pkg::dpsc_disp_t disp,
  input wire logic                 irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sr_no_grant: assert property (sdram_self_refresh |-> !mem_gnt) else $error("grant in self-refresh");
  a_grant_cause: assert property (mem_gnt |-> $past(mem_req)) else $error("grant without request");
  a_sr_clk_off: assert property ($rose(sdram_self_refresh) |=> !disp.mem_clk_en) else $error("mem clock on");
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_one_wait: assert property (psel && $rose(penable) |=> pready) else $error("no answer");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error");
  a_lcd_clk_on: assert property (disp.lcd_out_en |-> disp.lcd_clk_en) else $error("lcd clock gated");
  a_crt_pair: assert property (disp.crt_out_en == disp.crt_clk_en) else $error("crt pipe mismatch");
  a_sr_stays: assert property ($rose(sdram_self_refresh) |=> sdram_self_refresh [*8]) else $error("sr glitch");
  c_sr: cover property ($rose(sdram_self_refresh));
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_lcd: cover property ($rose(disp.lcd_out_en));
endmodule // dpsc_top_properties

// ===== bench/dpsc_host_model.sv
// host memory traffic: request and busy levels on command
`timescale 1ns/1ps
module dpsc_host_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       start,
  input wire logic [7:0] len,
  input wire logic       ps_on,
  input wire logic       rogue,
  output logic           mem_req,
  output logic           mem_busy
);
  logic [7:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (start) begin
      cnt_reg <= len;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // no request in power save unless a scenario breaks the rule
  assign mem_req  = (cnt_reg != 8'h00) && (!ps_on || rogue);
  assign mem_busy = (cnt_reg != 8'h00);
endmodule // dpsc_host_model

// ===== bench/dpsc_top_tb_top.sv
// testbench of the power save controller
`timescale 1ns/1ps
module dpsc_top_tb_top;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rdat;
  logic                 mem_req, mem_busy, mem_gnt, sdram_self_refresh, irq;
  logic                 start, ps_on, rogue, err;
  logic [3:0]           strb;
  logic [7:0]           len;
  dpsc_pkg::dpsc_disp_t disp;
  int                   fails, n_tests;
  dpsc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_busy(mem_busy), .mem_gnt(mem_gnt), .sdram_self_refresh(sdram_self_refresh),
    .disp(disp), .irq(irq));
  dpsc_host_model host (.pclk(pclk), .presetn(presetn), .start(start), .len(len), .ps_on(ps_on),
    .rogue(rogue), .mem_req(mem_req), .mem_busy(mem_busy));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (++k > 50) begin
        fails++;
        break;
      end
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdat);
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task go(input logic [7:0] n);
    @(posedge pclk);
    start <= 1'b1;
    len <= n;
    @(posedge pclk);
    start <= 1'b0;
  endtask
  task test_done;
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100_000;
    fails++;
    test_done;
  end
  initial begin
    {psel, penable, pwrite, start, ps_on, rogue} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    len = 8'h00;
    strb = 4'h1;
    fails = 0;
    n_tests = 0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("stat_rst", 12'h7c4, 32'h0000_0001);
    rd("cfg_rst", 12'h7c0, 32'h0000_0000);
    rd("unmapped", 12'h7d4, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    strb <= 4'h0;
    wr(12'h7c0, 32'h0000_0001);
    strb <= 4'h1;
    rd("cfg_nolane", 12'h7c0, 32'h0000_0000);
    wr(12'h7c8, 32'h0000_0003);
    wt(4);
    chk("crt_on", 32'h1, {31'h0, disp.crt_out_en});
    rd("stat_up", 12'h7c4, 32'h0000_0000);
    wt(220);
    chk("lcd_on", 32'h1, {31'h0, disp.lcd_out_en});
    go(8'h04);
    wt(2);
    chk("gnt", 32'h1, {31'h0, mem_gnt});
    wr(12'h7d0, 32'h0000_001f);
    go(8'd100);
    ps_on <= 1'b1;
    wr(12'h7c0, 32'h0000_0001);
    wt(3);
    chk("lcd_off", 32'h0, {31'h0, disp.lcd_out_en});
    chk("crt_off", 32'h0, {31'h0, disp.crt_out_en});
    rd("stat_drain", 12'h7c4, 32'h0000_0000);
    wt(130);
    chk("sr", 32'h1, {31'h0, sdram_self_refresh});
    chk("mclk", 32'h0, {31'h0, disp.mem_clk_en});
    rd("stat_sr", 12'h7c4, 32'h0000_0002);
    wr(12'h7c4, 32'h0000_0000);
    rd("mode_ps", 12'h7c8, 32'h0000_0003);
    rd("cfg_ps", 12'h7c0, 32'h0000_0001);
    rogue <= 1'b1;
    go(8'h04);
    wt(2);
    chk("no_gnt", 32'h0, {31'h0, mem_gnt});
    rogue <= 1'b0;
    wt(80);
    // the controller stopped the memory clock on entering self-refresh and stops the pixel clock once the panel is off; this read shows both down
    rd("stat_down", 12'h7c4, 32'h0000_0003);
    chk("lcd_clk_off", 32'h0, {31'h0, disp.lcd_clk_en});
    rd("irq_st", 12'h7cc, 32'h0000_001b);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(12'h7d0, 32'h0000_0004);
    wt(2);
    chk("irq_mask", 32'h0, {31'h0, irq});
    wr(12'h7cc, 32'h0000_001f);
    rd("irq_clr", 12'h7cc, 32'h0000_0000);
    ps_on <= 1'b0;
    wr(12'h7c0, 32'h0000_0000);
    wt(40);
    chk("sr_exit", 32'h0, {31'h0, sdram_self_refresh});
    chk("irq_wake", 32'h1, {31'h0, irq});
    rd("stat_exit", 12'h7c4, 32'h0000_0000);
    go(8'h04);
    wt(2);
    chk("gnt_exit", 32'h1, {31'h0, mem_gnt});
    chk("crt_back", 32'h1, {31'h0, disp.crt_out_en});
    wr(12'h7c8, 32'h0000_0001);
    wt(2);
    chk("crt_unused", 32'h0, {31'h0, disp.crt_out_en});
    chk("crt_clk_off", 32'h0, {31'h0, disp.crt_clk_en});
    test_done;
  end
endmodule // dpsc_top_tb_top

bind dpsc_top dpsc_top_properties chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_gnt(mem_gnt),
  .sdram_self_refresh(sdram_self_refresh), .disp(disp), .irq(irq));
